// ### common/clksel_consts.vh
/*
 Constants for the system clock selection and clock multiplier control block:
 register byte offsets, field positions, reset values, source codes and timing counts.
 Assumes a 32-bit APB register bus and a 200 MHz reference clock.
*/
// Operation
// - eight system clock choices are decoded from the source codes
// - fast rc clock is optionally divided by a three-bit postscale field
// - at power-on the source comes from the configuration source and mode fields
// - erased configuration starts in fast rc divided mode, code 111
// - instruction clock is the oscillator or multiplier output divided by two
// - multiplier input divided by field value plus two, giving 2 to 33
// - postscale of 2, 4 or 8; software keeps output 12.5 to 80 MHz
// - output equals input times feedback over prescale times postscale
// - source codes 000 through 111 map to the eight documented sources
// - primary mode field picks high-speed, standard crystal or external clock
// - read-only current source field reports the active source
// - writable requested source field, reset from configuration at power-on
// - in switch-only monitor configuration the switch lock bit blocks switching
// - pin select lock refuses writes to the pin select registers
// - switch request bit starts a switch; hardware clears it when done
// - feedback field encodes multiplier equal to value plus two
`ifndef CLKSEL_CONSTS_VH
`define CLKSEL_CONSTS_VH

// ==========================================================
// register byte offsets
`define OSC_CTRL_ADDR     12'h000
`define CLK_DIVISOR_ADDR  12'h004
`define FB_DIVISOR_ADDR   12'h008

// ==========================================================
// oscillator control fields
`define CUR_SRC_LSB       12
`define REQ_SRC_LSB       8
`define SW_LOCK_BIT       7
`define PIN_LOCK_BIT      6
`define LOCK_STAT_BIT     5
`define FAIL_FLAG_BIT     3
`define SEC_EN_BIT        1
`define SW_REQ_BIT        0

// ==========================================================
// divisor fields and reset values
`define RC_POST_LSB       8
`define MULT_POST_LSB     6
`define MULT_PRE_LSB      0
`define RC_POST_RST       3'h0
`define MULT_POST_RST     2'h1
`define MULT_PRE_RST      5'h00
`define MULT_FB_RST       9'h030

// ==========================================================
// source codes, primary modes, monitor configuration
`define SRC_FAST_RC       3'h0
`define SRC_FAST_RC_MULT  3'h1
`define SRC_PRIMARY       3'h2
`define SRC_PRIMARY_MULT  3'h3
`define SRC_SECONDARY     3'h4
`define SRC_SLOW_RC       3'h5
`define SRC_FAST_RC_DIV16 3'h6
`define SRC_FAST_RC_DIVN  3'h7
`define POR_SRC_RST       3'h7
`define PMODE_EXTERNAL    2'h0
`define PMODE_STANDARD    2'h1
`define PMODE_HIGH_SPEED  2'h2
`define PMODE_OFF         2'h3
`define MON_SWITCH_ONLY   2'h1
`define MON_BOTH_ON       2'h0
`define DIV16_SHIFT       4'h4
`define RC_POST_TOP_SHIFT 4'h8

// ==========================================================
// timing
`define CLK_PERIOD_NS     5
`define STARTUP_TIME_NS   1000
`define STARTUP_CYCLES    ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_SYNC_WAIT     2'h3

`endif

// ### logic/system_clock_select_pll.v
/*
 System clock source selection and clock multiplier control with an APB register slave.
 Assumes oscillator, fast rc, lock and fail pins are asynchronous to REF_CLK_IN and slow
 enough to be sampled at 200 MHz; configuration fields are static after power-on.
*/
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "clksel_consts.vh"

module system_clock_select_pll (
	// clock and reset
	input  wire        REF_CLK_IN,
	input  wire        RST_N_IN,
	// apb slave
	input  wire        PSEL_IN,
	input  wire        PENABLE_IN,
	input  wire        PWRITE_IN,
	input  wire [11:0] PADDR_IN,
	input  wire [31:0] PWDATA_IN,
	output wire [31:0] PRDATA_OUT,
	output wire        PREADY_OUT,
	output wire        PSLVERR_OUT,
	// configuration fields from program memory
	input  wire [2:0]  INIT_SOURCE_CFG_IN,
	input  wire [1:0]  PRIMARY_MODE_CFG_IN,
	input  wire [1:0]  SWITCH_MONITOR_CFG_IN,
	// oscillator side pins
	input  wire        OSC_CLK_IN,
	input  wire        FAST_RC_CLK_IN,
	input  wire        MULT_LOCKED_IN,
	input  wire        CLOCK_FAIL_IN,
	// multiplier input frequency and pin select write gate
	input  wire [15:0] MULT_INPUT_KHZ_IN,
	input  wire        PIN_SELECT_WR_IN,
	output wire        PIN_SELECT_WR_OK_OUT,
	// clock path control
	output wire [2:0]  CURRENT_SOURCE_OUT,
	output wire        MULT_ENABLE_OUT,
	output wire        PRIMARY_ENABLE_OUT,
	output wire [1:0]  PRIMARY_MODE_OUT,
	output wire        SECONDARY_ENABLE_OUT,
	output wire        SWITCH_BUSY_OUT,
	output wire [8:0]  FAST_RC_POSTSCALE_OUT,
	output wire [5:0]  PRESCALE_FACTOR_OUT,
	output wire [9:0]  FEEDBACK_FACTOR_OUT,
	output wire [3:0]  POSTSCALE_FACTOR_OUT,
	output wire [25:0] MULT_OUT_KHZ_OUT,
	output wire [25:0] INSTR_KHZ_OUT,
	// derived clocks
	output wire        FAST_RC_DIV_CLK_OUT,
	output wire        INSTR_CLK_OUT
);

	// ==========================================================
	// constants and functions
	localparam [1:0]  ST_POR    = 2'h0;
	localparam [1:0]  ST_START  = 2'h1;
	localparam [1:0]  ST_RUN    = 2'h2;
	localparam [1:0]  ST_SWITCH = 2'h3;
	localparam integer startup_cycles = `STARTUP_CYCLES;
	localparam [15:0]  startup_last   = startup_cycles[15:0] - 16'h0001;

	function uses_mult;
		input [2:0] src;
		begin
			uses_mult = (src == `SRC_FAST_RC_MULT) || (src == `SRC_PRIMARY_MULT);
		end
	endfunction

	function uses_primary;
		input [2:0] src;
		begin
			uses_primary = (src == `SRC_PRIMARY) || (src == `SRC_PRIMARY_MULT);
		end
	endfunction

	function [3:0] post_factor;
		input [1:0] code;
		begin
			case (code)
				2'h0: post_factor = 4'h2;
				2'h1: post_factor = 4'h4;
				2'h3: post_factor = 4'h8;
				default: post_factor = 4'h4;
			endcase
		end
	endfunction

	// ==========================================================
	// input synchronisers
	// bit order: fail, locked, fast rc, osc, monitor cfg, mode cfg, source cfg
	wire [10:0] async_in = {CLOCK_FAIL_IN, MULT_LOCKED_IN, FAST_RC_CLK_IN, OSC_CLK_IN,
		SWITCH_MONITOR_CFG_IN, PRIMARY_MODE_CFG_IN, INIT_SOURCE_CFG_IN};
	reg  [10:0] sync1_reg;
	reg  [10:0] sync2_reg;
	reg         fail_d_reg;
	reg         rc_d_reg;
	reg         osc_d_reg;

	always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sync1_reg  <= 11'h000;
			sync2_reg  <= 11'h000;
			fail_d_reg <= 1'b0;
			rc_d_reg   <= 1'b0;
			osc_d_reg  <= 1'b0;
		end else begin
			sync1_reg  <= async_in;
			sync2_reg  <= sync1_reg;
			fail_d_reg <= sync2_reg[10];
			rc_d_reg   <= sync2_reg[8];
			osc_d_reg  <= sync2_reg[7];
		end
	end

	wire [2:0] cfg_src   = sync2_reg[2:0];
	wire [1:0] cfg_mode  = sync2_reg[4:3];
	wire [1:0] cfg_mon   = sync2_reg[6:5];
	wire       osc_s     = sync2_reg[7];
	wire       rc_s      = sync2_reg[8];
	wire       locked_s  = sync2_reg[9];
	wire       fail_rise = sync2_reg[10] & ~fail_d_reg;
	wire       rc_rise   = rc_s & ~rc_d_reg;
	wire       osc_rise  = osc_s & ~osc_d_reg;

	// ==========================================================
	// register state
	reg [1:0]  state_reg,     state_next;
	reg [1:0]  por_cnt_reg,   por_cnt_next;
	reg [15:0] tmr_reg,       tmr_next;
	reg        done_reg,      done_next;
	reg [2:0]  cur_src_reg,   cur_src_next;
	reg [2:0]  req_src_reg,   req_src_next;
	reg [1:0]  pmode_reg,     pmode_next;
	reg [1:0]  mon_reg,       mon_next;
	reg        sw_lock_reg,   sw_lock_next;
	reg        pin_lock_reg,  pin_lock_next;
	reg        fail_reg,      fail_next;
	reg        sec_en_reg,    sec_en_next;
	reg        sw_req_reg,    sw_req_next;
	reg [2:0]  rc_post_reg,   rc_post_next;
	reg [1:0]  post_reg,      post_next;
	reg [4:0]  pre_reg,       pre_next;
	reg [8:0]  fb_reg,        fb_next;

	// ==========================================================
	// apb decode
	wire wr_acc   = PSEL_IN & PENABLE_IN & PWRITE_IN;
	wire rd_setup = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
	wire hit_osc  = (PADDR_IN == `OSC_CTRL_ADDR);
	wire hit_div  = (PADDR_IN == `CLK_DIVISOR_ADDR);
	wire hit_fb   = (PADDR_IN == `FB_DIVISOR_ADDR);
	wire mapped   = hit_osc | hit_div | hit_fb;

	// switching needs the switch-enable half of the configuration, and the lock
	// only bites when the monitor half is off
	wire sw_allowed   = ~mon_reg[1] & ~((mon_reg == `MON_SWITCH_ONLY) & sw_lock_reg);
	wire monitor_on   = (mon_reg == `MON_BOTH_ON);
	wire lock_status  = done_reg & (~uses_mult(cur_src_reg) | locked_s);
	wire target_ready = ~uses_mult(req_src_reg) | locked_s;

	always @* begin
		state_next    = state_reg;
		por_cnt_next  = por_cnt_reg;
		tmr_next      = tmr_reg;
		done_next     = done_reg;
		cur_src_next  = cur_src_reg;
		req_src_next  = req_src_reg;
		pmode_next    = pmode_reg;
		mon_next      = mon_reg;
		sw_lock_next  = sw_lock_reg;
		pin_lock_next = pin_lock_reg;
		fail_next     = fail_reg;
		sec_en_next   = sec_en_reg;
		sw_req_next   = sw_req_reg;
		rc_post_next  = rc_post_reg;
		post_next     = post_reg;
		pre_next      = pre_reg;
		fb_next       = fb_reg;

		case (state_reg)
			ST_POR: begin
				// wait for the configuration fields to pass the synchroniser
				if (por_cnt_reg == `POR_SYNC_WAIT) begin
					cur_src_next = cfg_src;
					req_src_next = cfg_src;
					pmode_next   = cfg_mode;
					mon_next     = cfg_mon;
					tmr_next     = 16'h0000;
					state_next   = ST_START;
				end else begin
					por_cnt_next = por_cnt_reg + 2'h1;
				end
			end
			ST_START: begin
				if (tmr_reg == startup_last) begin
					done_next  = 1'b1;
					state_next = ST_RUN;
				end else begin
					tmr_next = tmr_reg + 16'h0001;
				end
			end
			ST_RUN: begin
				if (sw_req_reg && sw_allowed) begin
					tmr_next   = 16'h0000;
					done_next  = 1'b0;
					state_next = ST_SWITCH;
				end else if (sw_req_reg) begin
					sw_req_next = 1'b0;
				end
			end
			ST_SWITCH: begin
				if (tmr_reg != startup_last) begin
					tmr_next = tmr_reg + 16'h0001;
				end else if (target_ready) begin
					cur_src_next = req_src_reg;
					sw_req_next  = 1'b0;
					done_next    = 1'b1;
					state_next   = ST_RUN;
				end
			end
			default: begin
				state_next = ST_POR;
			end
		endcase

		if (wr_acc && hit_osc) begin
			if (state_reg == ST_RUN) begin
				req_src_next = PWDATA_IN[`REQ_SRC_LSB +: 3];
				if (PWDATA_IN[`SW_REQ_BIT] && sw_allowed)
					sw_req_next = 1'b1;
			end
			sw_lock_next  = PWDATA_IN[`SW_LOCK_BIT];
			pin_lock_next = PWDATA_IN[`PIN_LOCK_BIT];
			sec_en_next   = PWDATA_IN[`SEC_EN_BIT];
			fail_next     = fail_reg & PWDATA_IN[`FAIL_FLAG_BIT];
		end
		if (wr_acc && hit_div) begin
			rc_post_next = PWDATA_IN[`RC_POST_LSB +: 3];
			post_next    = PWDATA_IN[`MULT_POST_LSB +: 2];
			pre_next     = PWDATA_IN[`MULT_PRE_LSB +: 5];
		end
		if (wr_acc && hit_fb) begin
			fb_next = PWDATA_IN[8:0];
		end

		// a detected failure falls back to fast rc and wins over a same-cycle clear
		if (fail_rise && monitor_on && state_reg != ST_POR) begin
			fail_next    = 1'b1;
			cur_src_next = `SRC_FAST_RC;
			sw_req_next  = 1'b0;
			done_next    = 1'b1;
			state_next   = ST_RUN;
		end
	end

	always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_reg    <= ST_POR;
			por_cnt_reg  <= 2'h0;
			tmr_reg      <= 16'h0000;
			done_reg     <= 1'b0;
			cur_src_reg  <= `POR_SRC_RST;
			req_src_reg  <= `POR_SRC_RST;
			pmode_reg    <= `PMODE_OFF;
			mon_reg      <= 2'h3;
			sw_lock_reg  <= 1'b0;
			pin_lock_reg <= 1'b0;
			fail_reg     <= 1'b0;
			sec_en_reg   <= 1'b0;
			sw_req_reg   <= 1'b0;
			rc_post_reg  <= `RC_POST_RST;
			post_reg     <= `MULT_POST_RST;
			pre_reg      <= `MULT_PRE_RST;
			fb_reg       <= `MULT_FB_RST;
		end else begin
			state_reg    <= state_next;
			por_cnt_reg  <= por_cnt_next;
			tmr_reg      <= tmr_next;
			done_reg     <= done_next;
			cur_src_reg  <= cur_src_next;
			req_src_reg  <= req_src_next;
			pmode_reg    <= pmode_next;
			mon_reg      <= mon_next;
			sw_lock_reg  <= sw_lock_next;
			pin_lock_reg <= pin_lock_next;
			fail_reg     <= fail_next;
			sec_en_reg   <= sec_en_next;
			sw_req_reg   <= sw_req_next;
			rc_post_reg  <= rc_post_next;
			post_reg     <= post_next;
			pre_reg      <= pre_next;
			fb_reg       <= fb_next;
		end
	end

	// ==========================================================
	// read data, captured in the setup phase for a zero-wait access
	reg  [31:0] prdata_reg;
	wire [31:0] osc_word = {16'h0000, 1'b0, cur_src_reg, 1'b0, req_src_reg,
		sw_lock_reg, pin_lock_reg, lock_status, 1'b0, fail_reg, 1'b0, sec_en_reg,
		sw_req_reg};
	wire [31:0] div_word = {21'h000000, rc_post_reg, post_reg, 1'b0, pre_reg};
	wire [31:0] fb_word  = {23'h000000, fb_reg};

	always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			prdata_reg <= 32'h00000000;
		end else if (rd_setup) begin
			prdata_reg <= hit_osc ? osc_word : hit_div ? div_word : hit_fb ? fb_word :
				32'h00000000;
		end
	end

	assign PRDATA_OUT  = prdata_reg;
	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;

	// ==========================================================
	// frequency arithmetic
	wire [5:0]  n_pre   = {1'b0, pre_reg} + 6'h02;
	wire [9:0]  m_fb    = {1'b0, fb_reg} + 10'h002;
	wire [3:0]  n_post  = post_factor(post_reg);
	wire [25:0] num     = {10'h000, MULT_INPUT_KHZ_IN} * {16'h0000, m_fb};
	wire [9:0]  den     = {4'h0, n_pre} * {6'h00, n_post};
	wire [25:0] mult_out = num / {16'h0000, den};
	wire [25:0] sys_khz  = uses_mult(cur_src_reg) ? mult_out : {10'h000, MULT_INPUT_KHZ_IN};

	// fast rc postscale as a shift: divided mode uses the field, divide-by-16 is fixed;
	// the top field code skips 1:128 and jumps straight to 1:256
	wire [3:0] rc_field_shift = (rc_post_reg == 3'h7) ? `RC_POST_TOP_SHIFT : {1'b0, rc_post_reg};
	wire [3:0] rc_shift = (cur_src_reg == `SRC_FAST_RC_DIVN)  ? rc_field_shift :
		(cur_src_reg == `SRC_FAST_RC_DIV16) ? `DIV16_SHIFT : 4'h0;

	reg [25:0] mult_khz_reg;
	reg [25:0] instr_khz_reg;
	reg [8:0]  rc_scale_reg;
	reg [5:0]  pre_f_reg;
	reg [9:0]  fb_f_reg;
	reg [3:0]  post_f_reg;
	reg        mult_en_reg;
	reg        prim_en_reg;
	reg        pin_ok_reg;

	always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			mult_khz_reg  <= 26'h0000000;
			instr_khz_reg <= 26'h0000000;
			rc_scale_reg  <= 9'h001;
			pre_f_reg     <= 6'h02;
			fb_f_reg      <= 10'h002;
			post_f_reg    <= 4'h2;
			mult_en_reg   <= 1'b0;
			prim_en_reg   <= 1'b0;
			pin_ok_reg    <= 1'b0;
		end else begin
			mult_khz_reg  <= mult_out;
			instr_khz_reg <= {1'b0, sys_khz[25:1]};
			rc_scale_reg  <= 9'h001 << rc_shift;
			pre_f_reg     <= n_pre;
			fb_f_reg      <= m_fb;
			post_f_reg    <= n_post;
			mult_en_reg   <= uses_mult(cur_src_reg);
			prim_en_reg   <= uses_primary(cur_src_reg);
			pin_ok_reg    <= PIN_SELECT_WR_IN & ~pin_lock_reg;
		end
	end

	// ==========================================================
	// derived clocks; both follow the sampled pins, so they carry sampling jitter
	reg       instr_clk_reg;
	reg       rc_div_reg;
	reg [7:0] rc_cnt_reg;
	wire [7:0] rc_half_last = (8'h01 << (rc_shift - 4'h1)) - 8'h01;

	always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			instr_clk_reg <= 1'b0;
			rc_div_reg    <= 1'b0;
			rc_cnt_reg    <= 8'h00;
		end else begin
			if (osc_rise)
				instr_clk_reg <= ~instr_clk_reg;
			if (rc_shift == 4'h0) begin
				rc_div_reg <= rc_s;
				rc_cnt_reg <= 8'h00;
			end else if (rc_rise) begin
				if (rc_cnt_reg >= rc_half_last) begin
					rc_div_reg <= ~rc_div_reg;
					rc_cnt_reg <= 8'h00;
				end else begin
					rc_cnt_reg <= rc_cnt_reg + 8'h01;
				end
			end
		end
	end

	// ==========================================================
	// outputs
	assign PIN_SELECT_WR_OK_OUT  = pin_ok_reg;
	assign CURRENT_SOURCE_OUT    = cur_src_reg;
	assign MULT_ENABLE_OUT       = mult_en_reg;
	assign PRIMARY_ENABLE_OUT    = prim_en_reg;
	assign PRIMARY_MODE_OUT      = pmode_reg;
	assign SECONDARY_ENABLE_OUT  = sec_en_reg;
	assign SWITCH_BUSY_OUT       = sw_req_reg;
	assign FAST_RC_POSTSCALE_OUT = rc_scale_reg;
	assign PRESCALE_FACTOR_OUT   = pre_f_reg;
	assign FEEDBACK_FACTOR_OUT   = fb_f_reg;
	assign POSTSCALE_FACTOR_OUT  = post_f_reg;
	assign MULT_OUT_KHZ_OUT      = mult_khz_reg;
	assign INSTR_KHZ_OUT         = instr_khz_reg;
	assign FAST_RC_DIV_CLK_OUT   = rc_div_reg;
	assign INSTR_CLK_OUT         = instr_clk_reg;

endmodule

// ### verif/clksel_properties.sv
/*
 Concurrent checks for the clock selection block, bound to its top module.
 Assumes the single 200 MHz reference clock and the asynchronous active-low reset.
*/
`timescale 1ns/1ps

module clksel_properties (
	// clock and reset
	input wire        REF_CLK_IN,
	input wire        RST_N_IN,
	// observed ports
	input wire        PIN_SELECT_WR_IN,
	input wire        PIN_SELECT_WR_OK_OUT,
	input wire [15:0] MULT_INPUT_KHZ_IN,
	input wire [2:0]  CURRENT_SOURCE_OUT,
	input wire        MULT_ENABLE_OUT,
	input wire        PRIMARY_ENABLE_OUT,
	input wire        SWITCH_BUSY_OUT,
	input wire        PSLVERR_OUT,
	input wire [8:0]  FAST_RC_POSTSCALE_OUT,
	input wire [5:0]  PRESCALE_FACTOR_OUT,
	input wire [9:0]  FEEDBACK_FACTOR_OUT,
	input wire [3:0]  POSTSCALE_FACTOR_OUT,
	input wire [25:0] MULT_OUT_KHZ_OUT,
	input wire [25:0] INSTR_KHZ_OUT
);
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	// ==========================================================
	// source decode
	wire mult_mode = (CURRENT_SOURCE_OUT == 3'h1) || (CURRENT_SOURCE_OUT == 3'h3);
	wire rc_plain = (CURRENT_SOURCE_OUT != 3'h6) && (CURRENT_SOURCE_OUT != 3'h7);

	chk_mult_en_track: assert property (MULT_ENABLE_OUT ==
		($past(CURRENT_SOURCE_OUT) == 3'h1 || $past(CURRENT_SOURCE_OUT) == 3'h3))
		else $error("multiplier enable does not follow the source");
	chk_prim_en_track: assert property (PRIMARY_ENABLE_OUT ==
		($past(CURRENT_SOURCE_OUT) == 3'h2 || $past(CURRENT_SOURCE_OUT) == 3'h3))
		else $error("primary enable does not follow the source");
	chk_rc_post_unity: assert property (rc_plain [*2] |-> FAST_RC_POSTSCALE_OUT == 9'h001)
		else $error("fast rc divided outside its modes");
	chk_rc_post_pow: assert property ($onehot(FAST_RC_POSTSCALE_OUT))
		else $error("fast rc divisor not a power of two");

	// ==========================================================
	// multiplier factors
	chk_pre_span: assert property (PRESCALE_FACTOR_OUT inside {[6'h02:6'h21]})
		else $error("prescale factor out of range");
	chk_post_codes: assert property (POSTSCALE_FACTOR_OUT inside {4'h2, 4'h4, 4'h8})
		else $error("postscale factor illegal");
	chk_fb_offset: assert property (FEEDBACK_FACTOR_OUT inside {[10'h002:10'h201]})
		else $error("feedback factor out of range");
	chk_out_product: assert property (($stable(PRESCALE_FACTOR_OUT) && $stable(FEEDBACK_FACTOR_OUT)
		&& $stable(POSTSCALE_FACTOR_OUT) && $stable(MULT_INPUT_KHZ_IN)) [*4] |->
		32'(MULT_OUT_KHZ_OUT) == (32'(MULT_INPUT_KHZ_IN) * FEEDBACK_FACTOR_OUT)
		/ (PRESCALE_FACTOR_OUT * POSTSCALE_FACTOR_OUT))
		else $error("multiplier output frequency wrong");
	chk_instr_mult: assert property ((mult_mode && $stable(MULT_OUT_KHZ_OUT)) [*4] |->
		INSTR_KHZ_OUT == {1'b0, MULT_OUT_KHZ_OUT[25:1]})
		else $error("instruction rate not half the multiplier output");
	chk_instr_direct: assert property ((!mult_mode && $stable(MULT_INPUT_KHZ_IN)) [*4] |->
		INSTR_KHZ_OUT == {11'h000, MULT_INPUT_KHZ_IN[15:1]})
		else $error("instruction rate not half the oscillator");
	chk_pin_gate: assert property (PIN_SELECT_WR_OK_OUT |-> $past(PIN_SELECT_WR_IN))
		else $error("pin select write passed without an attempt");

	cov_switch_done: cover property ($fell(SWITCH_BUSY_OUT));
	cov_mult_on: cover property ($rose(MULT_ENABLE_OUT));
	cov_bad_addr: cover property (PSLVERR_OUT);
endmodule

bind system_clock_select_pll clksel_properties clksel_properties_i (
	.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .PIN_SELECT_WR_IN(PIN_SELECT_WR_IN),
	.PIN_SELECT_WR_OK_OUT(PIN_SELECT_WR_OK_OUT), .MULT_INPUT_KHZ_IN(MULT_INPUT_KHZ_IN),
	.CURRENT_SOURCE_OUT(CURRENT_SOURCE_OUT), .MULT_ENABLE_OUT(MULT_ENABLE_OUT),
	.PRIMARY_ENABLE_OUT(PRIMARY_ENABLE_OUT), .SWITCH_BUSY_OUT(SWITCH_BUSY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .FAST_RC_POSTSCALE_OUT(FAST_RC_POSTSCALE_OUT),
	.PRESCALE_FACTOR_OUT(PRESCALE_FACTOR_OUT), .FEEDBACK_FACTOR_OUT(FEEDBACK_FACTOR_OUT),
	.POSTSCALE_FACTOR_OUT(POSTSCALE_FACTOR_OUT), .MULT_OUT_KHZ_OUT(MULT_OUT_KHZ_OUT),
	.INSTR_KHZ_OUT(INSTR_KHZ_OUT));

// ### verif/osc_source_model.sv
/*
 Behavioural oscillator side: divided clocks, a lock indication and a failure line.
 Assumes the bench reference clock; lock is counted from reset release.
*/
`timescale 1ns/1ps

module osc_source_model #(
	parameter int LOCK_CYCLES = 300
) (
	input  wire  clk_in,
	input  wire  rst_n_in,
	input  wire  fail_in,
	output logic osc_clk_out,
	output logic rc_clk_out,
	output logic locked_out,
	output logic fail_out
);
	logic [2:0] div_reg;
	logic [9:0] lock_cnt_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_reg <= 3'h0;
			lock_cnt_reg <= 10'h000;
		end else begin
			div_reg <= div_reg + 3'h1;
			if (lock_cnt_reg != 10'(LOCK_CYCLES))
				lock_cnt_reg <= lock_cnt_reg + 10'h001;
		end
	end

	// a failed oscillator stops dead instead of idling politely
	assign osc_clk_out = div_reg[2] & ~fail_in;
	assign rc_clk_out = div_reg[1];
	// lock is slower than the start-up timer so the lock wait gets exercised
	assign locked_out = (lock_cnt_reg == 10'(LOCK_CYCLES));
	assign fail_out = fail_in;
endmodule

// ### verif/tb_system_clock_select_pll.sv
/*
 Self-checking bench for the clock selection block, driving its APB slave.
 Assumes the oscillator model beside it and the bound property checker.
*/
`timescale 1ns/1ps
`include "clksel_consts.vh"
`define CHECK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
	$display("unexpected %0t got %0h want %0h", $time, (a), (e)); end end

module tb_system_clock_select_pll;
	logic        clk, rst_n, psel, penable, pwrite, pin_wr, fail_cmd, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [2:0]  init_cfg;
	logic [1:0]  pmode_cfg, mon_cfg, clk_seen;
	logic [15:0] in_khz;
	wire  [31:0] prdata;
	wire         pready, pslverr, pin_ok, osc_clk, rc_clk, locked, fail_pin;
	wire         mult_en, prim_en, sec_en, busy, rc_div_clk, instr_clk;
	wire  [2:0]  cur;
	wire  [1:0]  prim_mode;
	wire  [8:0]  rc_post;
	wire  [5:0]  pre_f;
	wire  [9:0]  fb_f;
	wire  [3:0]  post_f;
	wire  [25:0] mult_khz, instr_khz;
	int          err_count, comparisons;
	int          pre_t[5] = '{0, 31, 3, 1, 0};
	int          pc_t[5] = '{0, 1, 3, 2, 0};
	int          pf_t[5] = '{2, 4, 8, 4, 2};
	int          fb_t[5] = '{30, 511, 0, 100, 30};
	int          src_t[4] = '{2, 3, 6, 5};
	int          mode_t[4] = '{1, 0, 2, 1};

	system_clock_select_pll system_clock_select_pll_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
		.PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.INIT_SOURCE_CFG_IN(init_cfg), .PRIMARY_MODE_CFG_IN(pmode_cfg),
		.SWITCH_MONITOR_CFG_IN(mon_cfg), .OSC_CLK_IN(osc_clk), .FAST_RC_CLK_IN(rc_clk),
		.MULT_LOCKED_IN(locked), .CLOCK_FAIL_IN(fail_pin), .MULT_INPUT_KHZ_IN(in_khz),
		.PIN_SELECT_WR_IN(pin_wr), .PIN_SELECT_WR_OK_OUT(pin_ok), .CURRENT_SOURCE_OUT(cur),
		.MULT_ENABLE_OUT(mult_en), .PRIMARY_ENABLE_OUT(prim_en), .PRIMARY_MODE_OUT(prim_mode),
		.SECONDARY_ENABLE_OUT(sec_en), .SWITCH_BUSY_OUT(busy), .FAST_RC_POSTSCALE_OUT(rc_post),
		.PRESCALE_FACTOR_OUT(pre_f), .FEEDBACK_FACTOR_OUT(fb_f), .POSTSCALE_FACTOR_OUT(post_f),
		.MULT_OUT_KHZ_OUT(mult_khz), .INSTR_KHZ_OUT(instr_khz),
		.FAST_RC_DIV_CLK_OUT(rc_div_clk), .INSTR_CLK_OUT(instr_clk));

	osc_source_model osc_source_model_i (.clk_in(clk), .rst_n_in(rst_n), .fail_in(fail_cmd),
		.osc_clk_out(osc_clk), .rc_clk_out(rc_clk), .locked_out(locked), .fail_out(fail_pin));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// bus and sequencing tasks
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) begin
			err_count++;
			$display("unexpected %0t no ready", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_bit(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, `OSC_CTRL_ADDR, 32'h0);
			n++;
		end while (rd[b] !== v && n < 400);
		if (rd[b] !== v) begin
			err_count++;
			$display("unexpected %0t status wait expired", $time);
		end
	endtask

	task automatic do_reset(input logic [2:0] i, input logic [1:0] p, input logic [1:0] m);
		@(posedge clk);
		rst_n <= 1'b0;
		init_cfg <= i;
		pmode_cfg <= p;
		mon_cfg <= m;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		wait_bit(5, 1'b1);
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic pulse_pin(input logic e);
		@(posedge clk);
		pin_wr <= 1'b1;
		@(posedge clk);
		pin_wr <= 1'b0;
		#1;
		`CHECK(pin_ok, e)
	endtask

	task automatic finish_test();
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#200000;
		err_count++;
		$display("unexpected %0t run too long", $time);
		finish_test();
	end

	// ==========================================================
	// test sequence
	initial begin
		{psel, penable, pwrite, pin_wr, fail_cmd, rst_n} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		in_khz = 16'h2710;
		err_count = 0;
		comparisons = 0;
		do_reset(3'h7, 2'h2, 2'h1);
		`CHECK(rd, 32'h0000_7720)
		`CHECK(cur, `SRC_FAST_RC_DIVN)
		apb(1'b0, `CLK_DIVISOR_ADDR, 32'h0);
		`CHECK(rd, 32'h0000_0040)
		apb(1'b0, `FB_DIVISOR_ADDR, 32'h0);
		`CHECK(rd, 32'h0000_0030)
		apb(1'b0, 12'h00c, 32'h0);
		`CHECK({err, rd}, 33'h1_0000_0000)
		for (int f = 0; f < 8; f++) begin
			apb(1'b1, `CLK_DIVISOR_ADDR, 32'(f * 256 + 64));
			settle();
			`CHECK(rc_post, 9'(f == 7 ? 256 : 1 << f))
		end
		// last row is the legal set-up: 5 MHz into, 160 MHz out of the oscillator, 80 MHz out
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `CLK_DIVISOR_ADDR, 32'(pc_t[i] * 64 + pre_t[i]));
			apb(1'b1, `FB_DIVISOR_ADDR, 32'(fb_t[i]));
			settle();
			`CHECK(pre_f, 6'(pre_t[i] + 2))
			`CHECK(post_f, 4'(pf_t[i]))
			`CHECK(fb_f, 10'(fb_t[i] + 2))
			`CHECK(mult_khz, 26'(10000 * (fb_t[i] + 2) / ((pre_t[i] + 2) * pf_t[i])))
			`CHECK(instr_khz, 26'h0001388)
		end
		// undivided fast rc follows its pin; instruction clock toggles once per oscillator period
		clk_seen = {instr_clk, rc_div_clk};
		repeat (2) @(posedge clk);
		#1;
		`CHECK(rc_div_clk, !clk_seen[0])
		repeat (6) @(posedge clk);
		#1;
		`CHECK(instr_clk, !clk_seen[1])
		apb(1'b1, `OSC_CTRL_ADDR, 32'h0000_0301);
		apb(1'b0, `OSC_CTRL_ADDR, 32'h0);
		`CHECK(rd[5:0], 6'h01)
		`CHECK(busy, 1'b1)
		wait_bit(0, 1'b0);
		`CHECK({rd[14:12], rd[5]}, 4'h7)
		settle();
		`CHECK({mult_en, prim_en, prim_mode}, 4'he)
		`CHECK(mult_khz, 26'h0013880)
		`CHECK(instr_khz, 26'h0009c40)
		apb(1'b1, `OSC_CTRL_ADDR, 32'h0000_0380);
		apb(1'b1, `OSC_CTRL_ADDR, 32'h0000_0081);
		wait_bit(0, 1'b0);
		`CHECK(rd[14:12], 3'h3)
		// the lock is judged before the same word clears it, so it is cleared on its own first
		apb(1'b1, `OSC_CTRL_ADDR, 32'h0000_0000);
		apb(1'b1, `OSC_CTRL_ADDR, 32'h0000_0001);
		wait_bit(0, 1'b0);
		`CHECK(rd[14:12], 3'h0)
		settle();
		`CHECK(mult_en, 1'b0)
		apb(1'b1, `OSC_CTRL_ADDR, 32'h0000_0040);
		pulse_pin(1'b0);
		apb(1'b1, `OSC_CTRL_ADDR, 32'h0000_0002);
		pulse_pin(1'b1);
		`CHECK(sec_en, 1'b1)
		for (int i = 0; i < 4; i++) begin
			do_reset(3'(src_t[i]), 2'(mode_t[i]), 2'h0);
			`CHECK(rd[10:8], 3'(src_t[i]))
			`CHECK(cur, 3'(src_t[i]))
			settle();
			`CHECK({mult_en, prim_en, prim_mode}, {src_t[i] == 3, src_t[i] inside {2, 3},
				2'(mode_t[i])})
			`CHECK(rc_post, 9'(src_t[i] == 6 ? 16 : 1))
		end
		@(posedge clk);
		fail_cmd <= 1'b1;
		repeat (10) @(posedge clk);
		apb(1'b0, `OSC_CTRL_ADDR, 32'h0);
		`CHECK({rd[14:12], rd[3]}, 4'h1)
		fail_cmd <= 1'b0;
		apb(1'b1, `OSC_CTRL_ADDR, 32'h0);
		apb(1'b0, `OSC_CTRL_ADDR, 32'h0);
		`CHECK(rd[3], 1'b0)
		finish_test();
	end
endmodule
